// ---- rsa_consts.svh ----
`ifndef RSA_CONSTS_SVH
`define RSA_CONSTS_SVH

// Register offsets on the register port
`define RSA_OFS_BUCK34      8'h23
`define RSA_OFS_BACKUP      8'h24
`define RSA_OFS_SW_LDO      8'h25
`define RSA_OFS_OUTPIN      8'h26

// Reset values
`define RSA_RST_BUCK34      8'h75
`define RSA_RST_BACKUP      8'h12
`define RSA_RST_SW_LDO      8'h63
`define RSA_RST_OUTPIN      8'h03
// Rails sequenced under the reset codes: every rail but the output
`define RSA_RST_MANAGED     6'h1F

// Writable bits of the backup register, the rest read zero
`define RSA_MASK_BACKUP     8'h33

// Field positions
`define RSA_LO4_MSB         3
`define RSA_LO4_LSB         0
`define RSA_HI4_MSB         7
`define RSA_HI4_LSB         4
`define RSA_BK_A_MSB        1
`define RSA_BK_A_LSB        0
`define RSA_BK_B_MSB        5
`define RSA_BK_B_LSB        4

// Step codes
`define RSA_STEP_NONE       4'h0
`define RSA_STEP_ONE        4'h1
`define RSA_STEP_TWO        4'h2
`define RSA_STEP_THREE      4'h3
`define RSA_STEP_TEN        4'hA
`define RSA_BK_CODE_ONE     2'h1
`define RSA_BK_CODE_TWO     2'h2

// Timing
`define RSA_CLK_KHZ         50000
`define RSA_GAP_SHORT_MS    2
`define RSA_GAP_LONG_MS     5
`define RSA_DOWN_FACTOR     10
`define RSA_GAP_SHORT_CYC   (`RSA_GAP_SHORT_MS * `RSA_CLK_KHZ)
`define RSA_GAP_LONG_CYC    (`RSA_GAP_LONG_MS * `RSA_CLK_KHZ)

`endif

// ---- rsa_pkg.sv ----
package rsa_pkg;

  typedef logic [3:0] rsa_step_t;

  // The four step-select registers as stored
  typedef struct packed {
    logic [7:0] buck34;
    logic [7:0] backup;
    logic [7:0] sw_ldo;
    logic [7:0] outpin;
  } rsa_step_regs_s;

  // Sequencer phases
  typedef enum logic [3:0] {
    RSA_OFF  = 4'h1,
    RSA_UP   = 4'h2,
    RSA_ON   = 4'h4,
    RSA_DOWN = 4'h8
  } rsa_phase_e;

endpackage

// ---- rsa_rail_strobe.sv ----
`timescale 1ns/1ps
`include "rsa_consts.svh"

// What this block does
// [RULE1] Four-bit codes 3h to Ah enable the rail at steps three to ten.
// [RULE2] Four-bit codes 0h-2h and Bh-Fh leave the rail out of sequencing.
// [RULE3] Backup two-bit code 1h means step one, code 2h means step two.
// [RULE4] Backup two-bit codes 0h and 3h leave that converter unsequenced.
// [RULE5] Steps one and two run only while the freshness seal flag is 0.
// [RULE6] Once the seal is broken, sequencing never turns the backup converters off.
// [RULE7] Buck three field is bits 3-0, reset 5h, so step five.
// [RULE8] Backup register: b field bits 5-4 reset 1h, a field bits 1-0 reset 2h.
// [RULE9] Switch/regulator register: switch bits 7-4 reset 6h, regulator bits 3-0 reset 3h.
// [RULE10] Output register: output field bits 7-4 reset 0h, whole reset 03h.
// [RULE11] Each gap between steps lasts 2 ms or 5 ms by its select bit.
// [RULE12] Delay factor bit stretches power-down gaps tenfold, power-up unchanged.
// [RULE13] Fields are written only while unlocked; locked writes are ignored.
// [RULE14] Host turns on unsequenced rails through their own enables. This block has no such enables; o_rail_en is set only by sequencer strobes.
module rsa_rail_strobe #(
  parameter int unsigned GAP_SHORT_CYC = `RSA_GAP_SHORT_CYC,
  parameter int unsigned GAP_LONG_CYC  = `RSA_GAP_LONG_CYC
) (
  // Clock, reset, enable
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_b,
  input  wire logic                  i_ce,
  // Register port behind the serial decoder
  input  wire logic [7:0]            i_reg_addr,
  input  wire logic                  i_reg_wr,
  input  wire logic [7:0]            i_reg_wdata,
  input  wire logic                  i_reg_rd,
  input  wire logic                  i_reg_unlock,
  output logic      [7:0]            o_reg_rdata,
  output logic                       o_reg_ack,
  output logic                       o_reg_refused,
  // Sequencer control
  input  wire logic                  i_power_up_req,
  input  wire logic                  i_power_down_req,
  input  wire logic                  i_freshness_seal_flag,
  input  wire logic [8:0]            i_gap_long,
  input  wire logic                  i_powerdown_delay_factor,
  // Rail enables and status
  output logic      [5:0]            o_rail_en,
  output logic      [5:0]            o_rail_managed,
  output rsa_pkg::rsa_step_t         o_seq_step,
  output rsa_pkg::rsa_phase_e        o_seq_phase
);

  // Gap lengths held in 25 bits, room for a tenfold long gap at 50 MHz
  localparam int NRAIL = 6;
  localparam logic [24:0] SHORT_LEN = GAP_SHORT_CYC[24:0];
  localparam logic [24:0] LONG_LEN  = GAP_LONG_CYC[24:0];
  localparam logic [24:0] FACTOR    = 25'(`RSA_DOWN_FACTOR);

  // Registers
  rsa_pkg::rsa_step_regs_s regs_reg;
  rsa_pkg::rsa_step_regs_s regs_next;
  rsa_pkg::rsa_phase_e     phase_reg;
  rsa_pkg::rsa_phase_e     phase_next;
  rsa_pkg::rsa_step_t      step_reg;
  rsa_pkg::rsa_step_t      step_next;
  logic [24:0]             cnt_reg;
  logic [24:0]             cnt_next;
  logic [NRAIL-1:0]        en_reg;
  logic [NRAIL-1:0]        en_next;
  logic [NRAIL-1:0]        managed_reg;
  logic [NRAIL-1:0]        managed_next;
  logic [7:0]              rdata_reg;
  logic                    ack_reg;
  logic                    refused_reg;

  // Address decode
  wire sel_buck34 = (i_reg_addr == `RSA_OFS_BUCK34);
  wire sel_backup = (i_reg_addr == `RSA_OFS_BACKUP);
  wire sel_sw_ldo = (i_reg_addr == `RSA_OFS_SW_LDO);
  wire sel_outpin = (i_reg_addr == `RSA_OFS_OUTPIN);
  wire sel_any    = sel_buck34 | sel_backup | sel_sw_ldo | sel_outpin;

  // Locked writes never reach the fields
  wire wr_ok      = i_reg_wr & sel_any & i_reg_unlock; // [RULE13]
  wire wr_refuse  = i_reg_wr & ~wr_ok;

  // Register write path, reserved backup bits forced to zero
  always_comb begin
    regs_next = regs_reg;
    if (wr_ok && sel_buck34) begin
      regs_next.buck34 = i_reg_wdata;
    end
    if (wr_ok && sel_backup) begin
      regs_next.backup = i_reg_wdata & `RSA_MASK_BACKUP; // [RULE8]
    end
    if (wr_ok && sel_sw_ldo) begin
      regs_next.sw_ldo = i_reg_wdata;
    end
    if (wr_ok && sel_outpin) begin
      regs_next.outpin = i_reg_wdata;
    end
  end

  // Read mux, unmapped addresses read zero
  wire [7:0] rd_mux = sel_buck34 ? regs_reg.buck34 :
                      sel_backup ? regs_reg.backup :
                      sel_sw_ldo ? regs_reg.sw_ldo :
                      sel_outpin ? regs_reg.outpin : 8'h00;

  // Field extraction
  wire [3:0] buck3_step_field          = regs_reg.buck34[`RSA_LO4_MSB:`RSA_LO4_LSB]; // [RULE7]
  wire [1:0] backup_a_step_field       = regs_reg.backup[`RSA_BK_A_MSB:`RSA_BK_A_LSB];
  wire [1:0] backup_b_step_field       = regs_reg.backup[`RSA_BK_B_MSB:`RSA_BK_B_LSB];
  wire [3:0] load_switch_a_step_field  = regs_reg.sw_ldo[`RSA_HI4_MSB:`RSA_HI4_LSB]; // [RULE9]
  wire [3:0] linear_reg_step_field     = regs_reg.sw_ldo[`RSA_LO4_MSB:`RSA_LO4_LSB];
  wire [3:0] output_c_step_field       = regs_reg.outpin[`RSA_HI4_MSB:`RSA_HI4_LSB]; // [RULE10]

  // Four-bit code to step number, zero when unsequenced
  function automatic rsa_pkg::rsa_step_t map_wide(input logic [3:0] code);
    rsa_pkg::rsa_step_t s;
    s = `RSA_STEP_NONE;
    if (code >= `RSA_STEP_THREE && code <= `RSA_STEP_TEN) begin
      s = code; // [RULE1]
    end
    return s; // [RULE2]
  endfunction

  // Two-bit backup code to step number, zero when unsequenced
  function automatic rsa_pkg::rsa_step_t map_backup(input logic [1:0] code);
    rsa_pkg::rsa_step_t s;
    s = `RSA_STEP_NONE; // [RULE4]
    if (code == `RSA_BK_CODE_ONE) begin
      s = `RSA_STEP_ONE; // [RULE3]
    end else if (code == `RSA_BK_CODE_TWO) begin
      s = `RSA_STEP_TWO; // [RULE3]
    end
    return s;
  endfunction

  // Step of each rail, index order fixed
  rsa_pkg::rsa_step_t rail_step [NRAIL];
  assign rail_step[0] = map_wide(buck3_step_field);
  assign rail_step[1] = map_backup(backup_a_step_field);
  assign rail_step[2] = map_backup(backup_b_step_field);
  assign rail_step[3] = map_wide(load_switch_a_step_field);
  assign rail_step[4] = map_wide(linear_reg_step_field);
  assign rail_step[5] = map_wide(output_c_step_field);

  // Step of each rail as it will stand after this edge, so the flags can be registered
  rsa_pkg::rsa_step_t rail_step_next [NRAIL];
  assign rail_step_next[0] = map_wide(regs_next.buck34[`RSA_LO4_MSB:`RSA_LO4_LSB]);
  assign rail_step_next[1] = map_backup(regs_next.backup[`RSA_BK_A_MSB:`RSA_BK_A_LSB]);
  assign rail_step_next[2] = map_backup(regs_next.backup[`RSA_BK_B_MSB:`RSA_BK_B_LSB]);
  assign rail_step_next[3] = map_wide(regs_next.sw_ldo[`RSA_HI4_MSB:`RSA_HI4_LSB]);
  assign rail_step_next[4] = map_wide(regs_next.sw_ldo[`RSA_LO4_MSB:`RSA_LO4_LSB]);
  assign rail_step_next[5] = map_wide(regs_next.outpin[`RSA_HI4_MSB:`RSA_HI4_LSB]);

  // Backup rails are the ones the seal protects
  localparam logic [NRAIL-1:0] BACKUP_MASK = 6'h06;

  // Sequence span: the seal removes the first two steps
  wire rsa_pkg::rsa_step_t first_step =
    i_freshness_seal_flag ? `RSA_STEP_THREE : `RSA_STEP_ONE; // [RULE5]

  // Phase decode; a strobe fires once the gap counter has run out
  wire is_up    = (phase_reg == rsa_pkg::RSA_UP);
  wire is_down  = (phase_reg == rsa_pkg::RSA_DOWN);
  wire fire     = (is_up | is_down) & (cnt_reg == 25'h0000000);
  wire at_end   = is_up ? (step_reg == `RSA_STEP_TEN) : (step_reg <= first_step);

  // Seal raised mid power-up: strobes one and two are dropped, not run late
  wire skip_low = is_up & i_freshness_seal_flag & (step_reg < `RSA_STEP_THREE); // [RULE5]

  // Gap select: up gap follows this strobe, down gap precedes the lower one
  wire [3:0] gap_idx_up   = 4'(step_reg - 4'h1);
  wire [3:0] gap_idx_down = 4'(step_reg - 4'h2);
  wire [3:0] gap_idx      = is_up ? gap_idx_up : gap_idx_down;
  wire       gap_is_long  = (gap_idx < 4'h9) ? i_gap_long[gap_idx] : 1'b0;
  wire [24:0] gap_base    = gap_is_long ? LONG_LEN : SHORT_LEN; // [RULE11]
  wire [24:0] gap_len     = (is_down & i_powerdown_delay_factor) ?
                            25'(gap_base * FACTOR) : gap_base; // [RULE12]

  // Per-rail enable update at each strobe
  generate
    for (genvar r = 0; r < NRAIL; r++) begin : g_rail
      wire hit       = fire && !skip_low && (rail_step[r] != `RSA_STEP_NONE) &&
                       (rail_step[r] == step_reg);
      wire keep_on   = BACKUP_MASK[r] & i_freshness_seal_flag; // [RULE6]
      assign en_next[r] = (hit & is_up)              ? 1'b1 :
                          (hit & is_down & ~keep_on) ? 1'b0 : en_reg[r];
      assign managed_next[r] = (rail_step_next[r] != `RSA_STEP_NONE); // [RULE2]
    end
  endgenerate

  // Phase, step and gap counter
  always_comb begin
    phase_next = phase_reg;
    step_next  = step_reg;
    cnt_next   = cnt_reg;
    unique case (phase_reg)
      rsa_pkg::RSA_OFF: begin
        if (i_power_up_req) begin
          phase_next = rsa_pkg::RSA_UP;
          step_next  = first_step; // [RULE5]
          cnt_next   = 25'h0000000;
        end
      end
      rsa_pkg::RSA_ON: begin
        if (i_power_down_req) begin
          phase_next = rsa_pkg::RSA_DOWN;
          step_next  = `RSA_STEP_TEN;
          cnt_next   = 25'h0000000;
        end
      end
      rsa_pkg::RSA_UP,
      rsa_pkg::RSA_DOWN: begin
        if (skip_low) begin
          // Jump to strobe three at once; no gap is owed to a dropped strobe
          step_next = `RSA_STEP_THREE; // [RULE5]
          cnt_next  = 25'h0000000;
        end else if (!fire) begin
          cnt_next = 25'(cnt_reg - 25'h0000001);
        end else if (at_end) begin
          phase_next = is_up ? rsa_pkg::RSA_ON : rsa_pkg::RSA_OFF;
        end else begin
          step_next = is_up ? 4'(step_reg + 4'h1) : 4'(step_reg - 4'h1);
          cnt_next  = 25'(gap_len - 25'h0000001);
        end
      end
      default: begin
        phase_next = rsa_pkg::RSA_OFF;
      end
    endcase
  end

  // Field storage, reset to the programmed defaults
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      regs_reg    <= '{`RSA_RST_BUCK34, `RSA_RST_BACKUP, `RSA_RST_SW_LDO, `RSA_RST_OUTPIN}; // [RULE7]
      managed_reg <= `RSA_RST_MANAGED;
    end else if (i_ce) begin
      regs_reg    <= regs_next;
      managed_reg <= managed_next;
    end
  end

  // Sequencer state
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      phase_reg <= rsa_pkg::RSA_OFF;
      step_reg  <= `RSA_STEP_NONE;
      cnt_reg   <= 25'h0000000;
      en_reg    <= 6'h00;
    end else if (i_ce) begin
      phase_reg <= phase_next;
      step_reg  <= step_next;
      cnt_reg   <= cnt_next;
      en_reg    <= en_next;
    end
  end

  // Register port answer, one cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rdata_reg   <= 8'h00;
      ack_reg     <= 1'b0;
      refused_reg <= 1'b0;
    end else if (i_ce) begin
      if (i_reg_rd) begin
        rdata_reg <= rd_mux;
      end
      // Refused writes are acknowledged too, so the host never waits blind
      ack_reg     <= i_reg_rd | i_reg_wr;
      refused_reg <= wr_refuse;
    end
  end

  // Outputs
  assign o_reg_rdata   = rdata_reg;
  assign o_reg_ack     = ack_reg;
  assign o_reg_refused = refused_reg;
  assign o_rail_en     = en_reg;
  assign o_rail_managed = managed_reg;
  assign o_seq_step    = step_reg;
  assign o_seq_phase   = phase_reg;

endmodule

// ---- rsa_host_model.sv ----
`timescale 1ns/1ps
// Host end of the register port: one byte per request
module rsa_host_model (
  // Clock and answer
  input  wire logic       i_mclk,
  input  wire logic       i_ack,
  input  wire logic       i_refused,
  input  wire logic [7:0] i_rdata,
  // Request lines, idle from time zero
  output logic      [7:0] o_addr   = 8'h00,
  output logic            o_wr     = 1'b0,
  output logic      [7:0] o_wdata  = 8'h00,
  output logic            o_rd     = 1'b0,
  output logic            o_unlock = 1'b0
);
  // One-cycle strobe, answer taken at the edge after the strobe was seen
  task automatic xfer(input logic w, input logic [7:0] a, d, input logic ul,
                      output logic [7:0] q, output logic rf, ak);
    @(posedge i_mclk);
    o_addr   <= a;
    o_wdata  <= d;
    o_unlock <= ul;
    o_wr     <= w;
    o_rd     <= !w;
    @(posedge i_mclk);
    o_wr     <= 1'b0;
    o_rd     <= 1'b0;
    // Released lines carry junk so a stale byte cannot pass
    o_addr   <= ~a;
    o_wdata  <= ~d;
    @(posedge i_mclk);
    q  = i_rdata;
    rf = i_refused;
    ak = i_ack;
  endtask
endmodule

// ---- rsa_rail_strobe_sva.sv ----
`timescale 1ns/1ps
// Port-side watch on register answers and rail sequencing
module rsa_rail_strobe_sva (
  // Clock, reset, enable
  input wire logic                i_mclk,
  input wire logic                i_rst_b,
  input wire logic                i_ce,
  // Register port
  input wire logic [7:0]          i_reg_addr,
  input wire logic                i_reg_wr,
  input wire logic                i_reg_rd,
  input wire logic                i_reg_unlock,
  input wire logic                o_reg_ack,
  input wire logic                o_reg_refused,
  // Sequencer
  input wire logic                i_power_up_req,
  input wire logic                i_freshness_seal_flag,
  input wire logic [5:0]          o_rail_en,
  input wire logic [5:0]          o_rail_managed,
  input wire rsa_pkg::rsa_step_t  o_seq_step,
  input wire rsa_pkg::rsa_phase_e o_seq_phase
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // Request and map decode, mapped window is four bytes
  wire logic req_w = i_ce && (i_reg_rd || i_reg_wr);
  wire logic map_w = (i_reg_addr >= 8'h23) && (i_reg_addr <= 8'h26);
  sequence s_up_start;
    (o_seq_phase == rsa_pkg::RSA_OFF) && i_power_up_req && i_ce;
  endsequence
  sequence s_sealed_up;
    i_freshness_seal_flag [*2] ##0 (o_seq_phase == rsa_pkg::RSA_UP);
  endsequence
  ack_exact_a: assert property (req_w |=> o_reg_ack)
    else $error("ack missing after request");
  ack_quiet_a: assert property (i_ce && !i_reg_rd && !i_reg_wr |=> !o_reg_ack)
    else $error("ack without request");
  locked_refuse_a: assert property (i_ce && i_reg_wr && !i_reg_unlock |=> o_reg_refused)
    else $error("locked write not refused");
  open_accept_a: assert property (i_ce && i_reg_wr && i_reg_unlock && map_w |=> !o_reg_refused)
    else $error("open write refused");
  up_start_a: assert property (s_up_start |=> o_seq_phase == rsa_pkg::RSA_UP)
    else $error("power-up not started");
  step_range_a: assert property (o_seq_phase == rsa_pkg::RSA_UP |-> o_seq_step inside {[4'h1:4'hA]})
    else $error("step out of range");
  sealed_skip_a: assert property (s_sealed_up |-> o_seq_step >= 4'h3)
    else $error("sealed run used step one or two");
  backup_keep_a: assert property (i_freshness_seal_flag && o_rail_en[2:1] == 2'h3 |=> o_rail_en[2:1] == 2'h3)
    else $error("backup dropped under seal");
  rise_managed_a: assert property ((o_rail_en & ~$past(o_rail_en) & ~o_rail_managed) == 6'h00)
    else $error("unmanaged rail switched on");
endmodule

bind rsa_rail_strobe rsa_rail_strobe_sva u_sva (.i_mclk, .i_rst_b, .i_ce, .i_reg_addr,
  .i_reg_wr, .i_reg_rd, .i_reg_unlock, .o_reg_ack, .o_reg_refused, .i_power_up_req,
  .i_freshness_seal_flag, .o_rail_en, .o_rail_managed, .o_seq_step, .o_seq_phase);

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  // Bench state
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic up_req = 1'b0;
  logic dn_req = 1'b0;
  logic seal = 1'b0;
  logic fctr = 1'b0;
  logic [8:0] gap_long = 9'h000;
  logic [7:0] addr, wdata, rdata, q;
  logic wr, rd, unlock, ack, refd, rf, ak;
  logic [5:0] en, mgd, en_q = 6'h00;
  rsa_pkg::rsa_step_t step;
  rsa_pkg::rsa_phase_e phase;
  int cyc = 0;
  int error_cnt = 0;
  int num_checks = 0;
  int rise_t [6];
  int fall_t [6];
  // Rise offsets from step one: gap one long (10), the rest short (4)
  localparam logic [15:0] UPT [6] = '{16'h16, 16'h0A, 16'h00, 16'h1A, 16'h0E, 16'h12};
  // Short counts keep the run brief
  rsa_rail_strobe #(.GAP_SHORT_CYC(4), .GAP_LONG_CYC(10)) dut (.i_mclk(i_mclk),
    .i_rst_b(i_rst_b), .i_ce(1'b1), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
    .i_reg_rd(rd), .i_reg_unlock(unlock), .o_reg_rdata(rdata), .o_reg_ack(ack),
    .o_reg_refused(refd), .i_power_up_req(up_req), .i_power_down_req(dn_req),
    .i_freshness_seal_flag(seal), .i_gap_long(gap_long), .i_powerdown_delay_factor(fctr),
    .o_rail_en(en), .o_rail_managed(mgd), .o_seq_step(step), .o_seq_phase(phase));
  rsa_host_model host (.i_mclk(i_mclk), .i_ack(ack), .i_refused(refd), .i_rdata(rdata),
    .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd), .o_unlock(unlock));
  initial begin
    forever #10 i_mclk = ~i_mclk;
  end
  // Edge times of each rail, plus the hang guard
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    en_q <= en;
    for (int k = 0; k < 6; k++) begin
      if (en[k] && !en_q[k]) rise_t[k] <= cyc;
      if (!en[k] && en_q[k]) fall_t[k] <= cyc;
    end
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic wr_b(input logic [7:0] a, d, input logic ul, exp_rf);
    host.xfer(1'b1, a, d, ul, q, rf, ak);
    chk(16'(ak), 16'h0001, "write ack");
    chk(16'(rf), 16'(exp_rf), "write refusal");
  endtask
  task automatic rd_b(input logic [7:0] a, exp);
    host.xfer(1'b0, a, 8'h00, 1'b1, q, rf, ak);
    chk(16'(q), 16'(exp), "read data");
  endtask
  // Level request held one cycle, taken on the first edge
  task automatic go(input logic u);
    @(posedge i_mclk);
    up_req <= u;
    dn_req <= !u;
    @(posedge i_mclk);
    up_req <= 1'b0;
    dn_req <= 1'b0;
  endtask
  task automatic wait_ph(input rsa_pkg::rsa_phase_e p);
    int n;
    n = 0;
    while (phase !== p && n < 1000) begin
      @(posedge i_mclk);
      n++;
    end
    repeat (2) @(posedge i_mclk);
    chk(16'(phase), 16'(p), "phase");
  endtask
  task automatic t_regs();
    rd_b(8'h23, 8'h75);
    rd_b(8'h24, 8'h12);
    rd_b(8'h25, 8'h63);
    rd_b(8'h26, 8'h03);
    rd_b(8'h27, 8'h00);
    wr_b(8'h24, 8'hFF, 1'b1, 1'b0);
    rd_b(8'h24, 8'h33);
    wr_b(8'h25, 8'h00, 1'b0, 1'b1);
    rd_b(8'h25, 8'h63);
    wr_b(8'h30, 8'h55, 1'b1, 1'b1);
    $display("done registers");
  endtask
  task automatic t_codes();
    for (int c = 0; c < 16; c++) begin
      wr_b(8'h23, {4'h7, 4'(c)}, 1'b1, 1'b0);
      chk(16'(mgd[0]), 16'((c > 2) && (c < 11)), "nibble code");
    end
    for (int c = 0; c < 4; c++) begin
      wr_b(8'h24, {6'h04, 2'(c)}, 1'b1, 1'b0);
      chk(16'(mgd[1]), 16'((c == 1) || (c == 2)), "backup code");
    end
    wr_b(8'h23, 8'h75, 1'b1, 1'b0);
    wr_b(8'h24, 8'h12, 1'b1, 1'b0);
    wr_b(8'h26, 8'h43, 1'b1, 1'b0);
    $display("done codes");
  endtask
  // Up with factor set, then down sealed with factor
  task automatic t_updown();
    fctr <= 1'b1;
    gap_long <= 9'h001;
    go(1'b1);
    wait_ph(rsa_pkg::RSA_ON);
    for (int k = 0; k < 6; k++) chk(16'(rise_t[k] - rise_t[2]), UPT[k], "up gap");
    chk(16'(en), 16'h003F, "all on");
    seal <= 1'b1;
    go(1'b0);
    wait_ph(rsa_pkg::RSA_OFF);
    chk(16'(en), 16'h0006, "backups kept");
    chk(16'(fall_t[4] - fall_t[0]), 16'h0050, "down gap");
    chk(16'(fall_t[5] - fall_t[0]), 16'h0028, "down gap");
    $display("done sequencing");
  endtask
  task automatic t_sealed();
    i_rst_b <= 1'b0;
    gap_long <= 9'h000;
    fctr <= 1'b0;
    repeat (16) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    go(1'b1);
    wait_ph(rsa_pkg::RSA_ON);
    chk(16'(en), 16'h0019, "sealed up");
    chk(16'(rise_t[0] - rise_t[4]), 16'h0008, "sealed gap");
    $display("done sealed");
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    t_regs();
    t_codes();
    t_updown();
    t_sealed();
    end_of_test();
  end
endmodule
